// *** hw/intc_pkg.sv ***
// Types shared by the interrupt priority block
package intc_pkg;
	typedef logic [1:0] level_t;
	typedef logic [4:0] src_t;
	typedef enum logic [1:0] {
		BR_OKAY   = 2'b00,
		BR_SLVERR = 2'b10
	} bresp_t;
endpackage

// *** hw/intc_regs.svh ***
// Register offsets, reset values, field positions and timing of the interrupt priority block
`ifndef INTC_REGS_SVH
`define INTC_REGS_SVH

// Register indices; byte address = index * 4 (printed offsets are not all multiples of four)
`define IDX_PRIO_HIGH_BASE       8'hb7
`define IDX_PRIO_LOW_BASE        8'hb8
`define IDX_PRIO_LOW_EXT         8'hef
`define IDX_PRIO_HIGH_EXT        8'hf7
`define IDX_PRIO_LOW_EXT_SECOND  8'hfe
`define IDX_PRIO_HIGH_EXT_SECOND 8'hff
// Own registers, byte address = index * 4
`define IDX_SERVICE_STATUS       8'h40
`define IDX_VECTOR_STATUS        8'h41

// Reset values
`define RST_PRIO                 8'h00

// Writable masks
`define MASK_BASE                8'h7f
`define MASK_EXT                 8'hff
`define MASK_EXT_SECOND          8'h07

// Field positions of the base group
`define BIT_EXT0                 0
`define BIT_TIMER0               1
`define BIT_EXT1                 2
`define BIT_TIMER1               3
`define BIT_SERIAL0              4
`define BIT_BROWNOUT             5
`define BIT_ADC                  6
// Field positions of the extended group
`define BIT_I2C                  0
`define BIT_PIN                  1
`define BIT_CAPTURE              2
`define BIT_PWM                  3
`define BIT_WDT                  4
`define BIT_FAULT                5
`define BIT_SPI                  6
`define BIT_TIMER2               7
// Field positions of the second extended group
`define BIT_SERIAL1              0
`define BIT_TIMER3               1
`define BIT_WAKEUP               2

// Hardware call length in clock cycles
`define CALL_CYCLES              4

`endif

// *** hw/interrupt_priority_vectoring.sv ***
// Interrupt priority resolution, vectoring and in-service tracking
`timescale 1ns/1ps
`include "intc_regs.svh"

// Notes on behaviour
// - Base low register, bits 6..0 ADC..external 0, bit 7 unused, reset zero.
// - Base high register, same positions as base low, reset zero.
// - Extended low register, bits 7..0 timer 2 down to I2C, reset zero.
// - Extended high register, same eight sources and positions, reset zero.
// - Second extended low, bit 2 wake-up, 1 timer 3, 0 serial 1.
// - Second extended high, bits 2..0 wake-up, timer 3, serial 1, reset zero.
// - Level of a source is its high bit joined with its low bit.
// - Flags sampled, polled and resolved every clock in one cycle.
// - No call while equal or higher level is in service.
// - Call only on the last cycle of the current instruction.
// - No call when instruction writes enable or priority bits, or is return-from-interrupt.
// - Blocked requests are not remembered; every poll starts anew.
// - Vectoring pushes program counter, not status word, then loads vector.
// - Flag clearing on vectoring is left to each source.
// - Return-from-interrupt pops program counter and ends the current service level.
// - Plain return restores program counter and leaves service state set.
// - Four levels, high/low pair 00..11 gives level 0..3.
// - Same level ties go to higher natural priority; no preemption by it.
// - Hardware vector call takes four clock cycles.
module interrupt_priority_vectoring
	import intc_pkg::*;
#(
	parameter int NUM_SRC = 18
) (
	input  wire logic               sys_clk,
	input  wire logic               srst,
	// Request flags in natural priority order, bit 0 highest
	input  wire logic [NUM_SRC-1:0] irq_flag,
	// Core status for the call decision
	input  wire logic               instr_last_cycle,
	input  wire logic               instr_writes_int_cfg,
	input  wire logic               instr_is_return_from_interrupt,
	input  wire logic               instr_is_ret,
	// Call towards the core
	output logic                    call_start,
	output logic                    call_busy,
	output logic                    call_push_pc,
	output logic                    call_save_status,
	output logic                    call_load_vector,
	output logic [4:0]              call_source,
	output logic                    pop_pc,
	output logic                    flag_ack_valid,
	output logic [4:0]              flag_ack_source,
	output logic [3:0]              in_service,
	// AXI4-Lite slave
	input  wire logic [9:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [9:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready
);

	// Priority registers
	logic [7:0] prio_low_base;
	logic [7:0] prio_high_base;
	logic [7:0] prio_low_ext;
	logic [7:0] prio_high_ext;
	logic [7:0] prio_low_ext_second;
	logic [7:0] prio_high_ext_second;

	// Bus holding registers
	logic        aw_held;
	logic        w_held;
	logic [9:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// Call sequencer
	logic [2:0]  call_cnt;
	logic [NUM_SRC-1:0] sampled;
	level_t      win_level;
	logic [4:0]  win_src;
	logic        win_valid;
	logic        accept;

	// Map from natural priority index to register pair and bit
	function automatic level_t src_level(input int s);
		logic lo;
		logic hi;
		begin
			lo = 1'b0;
			hi = 1'b0;
			unique case (s)
				0: begin lo = prio_low_base[`BIT_EXT0];        hi = prio_high_base[`BIT_EXT0]; end
				1: begin lo = prio_low_base[`BIT_BROWNOUT];    hi = prio_high_base[`BIT_BROWNOUT]; end
				2: begin lo = prio_low_ext[`BIT_WDT];          hi = prio_high_ext[`BIT_WDT]; end
				3: begin lo = prio_low_base[`BIT_TIMER0];      hi = prio_high_base[`BIT_TIMER0]; end
				4: begin lo = prio_low_ext[`BIT_I2C];          hi = prio_high_ext[`BIT_I2C]; end
				5: begin lo = prio_low_base[`BIT_ADC];         hi = prio_high_base[`BIT_ADC]; end
				6: begin lo = prio_low_base[`BIT_EXT1];        hi = prio_high_base[`BIT_EXT1]; end
				7: begin lo = prio_low_ext[`BIT_PIN];          hi = prio_high_ext[`BIT_PIN]; end
				8: begin lo = prio_low_base[`BIT_TIMER1];      hi = prio_high_base[`BIT_TIMER1]; end
				9: begin lo = prio_low_base[`BIT_SERIAL0];     hi = prio_high_base[`BIT_SERIAL0]; end
				10: begin lo = prio_low_ext[`BIT_FAULT];       hi = prio_high_ext[`BIT_FAULT]; end
				11: begin lo = prio_low_ext[`BIT_SPI];         hi = prio_high_ext[`BIT_SPI]; end
				12: begin lo = prio_low_ext[`BIT_TIMER2];      hi = prio_high_ext[`BIT_TIMER2]; end
				13: begin lo = prio_low_ext[`BIT_CAPTURE];     hi = prio_high_ext[`BIT_CAPTURE]; end
				14: begin lo = prio_low_ext[`BIT_PWM];         hi = prio_high_ext[`BIT_PWM]; end
				15: begin lo = prio_low_ext_second[`BIT_SERIAL1]; hi = prio_high_ext_second[`BIT_SERIAL1]; end
				16: begin lo = prio_low_ext_second[`BIT_TIMER3];  hi = prio_high_ext_second[`BIT_TIMER3]; end
				17: begin lo = prio_low_ext_second[`BIT_WAKEUP];  hi = prio_high_ext_second[`BIT_WAKEUP]; end
				default: begin lo = 1'b0; hi = 1'b0; end
			endcase
			src_level = {hi, lo};
		end
	endfunction

	// Highest set in-service level, or none
	function automatic logic [3:0] top_only(input logic [3:0] v);
		begin
			if (v[3])
				top_only = 4'h8;
			else if (v[2])
				top_only = 4'h4;
			else if (v[1])
				top_only = 4'h2;
			else
				top_only = {3'b000, v[0]};
		end
	endfunction

	// Live sample of flags; no pending memory kept
	assign sampled = irq_flag;

	// Resolve the winner: highest level, then lowest natural index
	always_comb begin
		win_valid = 1'b0;
		win_level = 2'b00;
		win_src   = 5'h00;
		for (int s = NUM_SRC - 1; s >= 0; s--) begin
			if (sampled[s] && (!win_valid || src_level(s) >= win_level)) begin
				win_valid = 1'b1;
				win_level = src_level(s);
				win_src   = 5'(s);
			end
		end
	end

	// Acceptance gate for a new call
	always_comb begin
		accept = win_valid && !call_busy
			&& (top_only(in_service) < (4'h1 << win_level))
			&& instr_last_cycle
			&& !instr_writes_int_cfg && !instr_is_return_from_interrupt && !call_srst_block();
	end

	// Synchronous reset also blocks a call, beyond the listed conditions
	function automatic logic call_srst_block();
		call_srst_block = srst;
	endfunction

	// Call sequencer of fixed length
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			call_cnt    <= 3'h0;
			call_source <= 5'h00;
		end else if (accept) begin
			call_cnt    <= 3'(`CALL_CYCLES);
			call_source <= win_src;
		end else if (call_cnt != 3'h0) begin
			call_cnt <= call_cnt - 3'h1;
		end
	end

	assign call_start       = accept;
	assign call_busy        = (call_cnt != 3'h0);
	assign call_push_pc     = (call_cnt == 3'(`CALL_CYCLES));
	assign call_load_vector = (call_cnt == 3'h1);
	assign call_save_status = 1'b0;
	assign pop_pc           = instr_is_return_from_interrupt || instr_is_ret;
	// Acknowledge only; each source decides whether to clear
	assign flag_ack_valid   = call_load_vector;
	assign flag_ack_source  = call_source;

	// In-service tracking, one flag per level
	always_ff @(posedge sys_clk) begin
		if (srst)
			in_service <= 4'h0;
		else if (accept)
			in_service <= in_service | (4'h1 << win_level);
		else if (instr_is_return_from_interrupt && instr_last_cycle)
			in_service <= in_service & ~top_only(in_service);
	end

	// AXI write channel capture
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 10'h000;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;

	// Write response and decode error
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= BR_OKAY;
		end else if (s_axi_bvalid) begin
			if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end else if (aw_held && w_held) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= mapped(aw_addr[9:2]) ? BR_OKAY : BR_SLVERR;
		end
	end

	function automatic logic mapped(input logic [7:0] idx);
		mapped = (idx == `IDX_PRIO_HIGH_BASE) || (idx == `IDX_PRIO_LOW_BASE)
			|| (idx == `IDX_PRIO_LOW_EXT) || (idx == `IDX_PRIO_HIGH_EXT)
			|| (idx == `IDX_PRIO_LOW_EXT_SECOND) || (idx == `IDX_PRIO_HIGH_EXT_SECOND)
			|| (idx == `IDX_SERVICE_STATUS) || (idx == `IDX_VECTOR_STATUS);
	endfunction

	// Register writes, lane 0 only
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prio_low_base        <= `RST_PRIO;
			prio_high_base       <= `RST_PRIO;
			prio_low_ext         <= `RST_PRIO;
			prio_high_ext        <= `RST_PRIO;
			prio_low_ext_second  <= `RST_PRIO;
			prio_high_ext_second <= `RST_PRIO;
		end else if (aw_held && w_held && !s_axi_bvalid && w_strb[0]) begin
			unique case (aw_addr[9:2])
				`IDX_PRIO_LOW_BASE:        prio_low_base  <= w_data[7:0] & `MASK_BASE;
				`IDX_PRIO_HIGH_BASE:       prio_high_base <= w_data[7:0] & `MASK_BASE;
				`IDX_PRIO_LOW_EXT:         prio_low_ext   <= w_data[7:0] & `MASK_EXT;
				`IDX_PRIO_HIGH_EXT:        prio_high_ext  <= w_data[7:0] & `MASK_EXT;
				`IDX_PRIO_LOW_EXT_SECOND:  prio_low_ext_second  <= w_data[7:0] & `MASK_EXT_SECOND;
				`IDX_PRIO_HIGH_EXT_SECOND: prio_high_ext_second <= w_data[7:0] & `MASK_EXT_SECOND;
				default: ;
			endcase
		end
	end

	// Read channel
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= BR_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end else if (s_axi_arvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= mapped(s_axi_araddr[9:2]) ? BR_OKAY : BR_SLVERR;
			unique case (s_axi_araddr[9:2])
				`IDX_PRIO_LOW_BASE:        s_axi_rdata <= {24'h0, prio_low_base};
				`IDX_PRIO_HIGH_BASE:       s_axi_rdata <= {24'h0, prio_high_base};
				`IDX_PRIO_LOW_EXT:         s_axi_rdata <= {24'h0, prio_low_ext};
				`IDX_PRIO_HIGH_EXT:        s_axi_rdata <= {24'h0, prio_high_ext};
				`IDX_PRIO_LOW_EXT_SECOND:  s_axi_rdata <= {24'h0, prio_low_ext_second};
				`IDX_PRIO_HIGH_EXT_SECOND: s_axi_rdata <= {24'h0, prio_high_ext_second};
				`IDX_SERVICE_STATUS:       s_axi_rdata <= {28'h0, in_service};
				`IDX_VECTOR_STATUS:        s_axi_rdata <= {23'h0, call_busy, 3'h0, call_source};
				default:                   s_axi_rdata <= 32'h0000_0000;
			endcase
		end
	end

	assign s_axi_arready = !s_axi_rvalid;

endmodule

// *** verif/core_model.sv ***
// Core and request source model: runs one instruction per go pulse
`timescale 1ns/1ps
module core_model (
	input  wire logic        sys_clk,
	input  wire logic        go,
	input  wire logic [17:0] f,
	input  wire logic [1:0]  len,
	input  wire logic [2:0]  kind,
	output logic [17:0]      irq_flag,
	output logic             instr_last_cycle,
	output logic             instr_writes_int_cfg,
	output logic             instr_is_return_from_interrupt,
	output logic             instr_is_ret,
	output logic             busy
);
	logic [1:0]  cnt = 2'h0;
	logic [2:0]  k = 3'h0;
	logic [17:0] fl = 18'h0;
	// Instruction length countdown with flags held throughout
	always_ff @(posedge sys_clk) begin
		if (go && cnt == 2'h0) begin
			cnt <= len;
			k <= kind;
			fl <= f;
		end else if (cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
		end
	end
	// Flags and qualifiers released between instructions
	assign busy = (cnt != 2'h0);
	assign irq_flag = busy ? fl : 18'h0;
	assign instr_last_cycle = (cnt == 2'h1);
	assign instr_writes_int_cfg = busy & k[0];
	assign instr_is_return_from_interrupt = busy & k[1];
	assign instr_is_ret = busy & k[2];
endmodule

// *** verif/intc_checker.sv ***
// Port assertions for the interrupt priority block
`timescale 1ns/1ps
module intc_checker
	import intc_pkg::*;
#(
	parameter int NUM_SRC = 18
) (
	input wire logic               sys_clk,
	input wire logic               srst,
	input wire logic [NUM_SRC-1:0] irq_flag,
	input wire logic               instr_last_cycle,
	input wire logic               instr_writes_int_cfg,
	input wire logic               instr_is_return_from_interrupt,
	input wire logic               instr_is_ret,
	input wire logic               call_start,
	input wire logic               call_busy,
	input wire logic               call_push_pc,
	input wire logic               call_save_status,
	input wire logic               call_load_vector,
	input wire logic [4:0]         call_source,
	input wire logic               pop_pc,
	input wire logic               flag_ack_valid,
	input wire logic [4:0]         flag_ack_source,
	input wire logic [3:0]         in_service
);
	// Flags of the previous cycle, indexed by the source that was taken
	logic [NUM_SRC-1:0] flag_prev;
	always_ff @(posedge sys_clk) begin
		flag_prev <= irq_flag;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	a_no_status_save: assert property (!call_save_status)
		else $error("status word saved on call");
	a_call_last_cycle: assert property (call_start |-> instr_last_cycle)
		else $error("call outside last instruction cycle");
	a_call_not_cfg: assert property (call_start |-> !instr_writes_int_cfg && !instr_is_return_from_interrupt)
		else $error("call during config write or return");
	a_call_four_cycles: assert property (call_start |=> call_push_pc ##3 call_load_vector ##1 !call_busy)
		else $error("call sequence not four cycles");
	a_call_needs_flag: assert property (call_start |=> flag_prev[call_source])
		else $error("call for an inactive flag");
	a_top_level_blocks: assert property (in_service[3] |-> !call_start)
		else $error("call while top level in service");
	a_ack_matches: assert property (flag_ack_valid |-> call_load_vector && flag_ack_source == call_source)
		else $error("flag ack source wrong");
	a_return_from_interrupt_clears: assert property (instr_is_return_from_interrupt && instr_last_cycle && |in_service && !call_start |=> in_service < $past(in_service))
		else $error("return did not end service level");
	a_ret_keeps: assert property (instr_is_ret && !instr_is_return_from_interrupt && !call_start |=> $stable(in_service))
		else $error("plain return changed service state");
	a_pop_on_return: assert property (pop_pc == (instr_is_return_from_interrupt || instr_is_ret))
		else $error("pop not tied to return");
endmodule

// *** verif/interrupt_priority_vectoring_test.sv ***
// Self-checking bench for the interrupt priority block
`timescale 1ns/1ps
`include "intc_regs.svh"
module interrupt_priority_vectoring_test;
	logic        sys_clk, srst, go, busy, pop_pc, flag_ack_valid;
	logic [17:0] irq_flag, f;
	logic [1:0]  len, s_axi_bresp, s_axi_rresp;
	logic [2:0]  kind;
	logic        instr_last_cycle, instr_writes_int_cfg, instr_is_return_from_interrupt, instr_is_ret;
	logic        call_start, call_busy, call_push_pc, call_save_status, call_load_vector;
	logic [4:0]  call_source, flag_ack_source;
	logic [3:0]  in_service, s_axi_wstrb;
	logic [9:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          error_cnt, checked, n_call;
	logic [33:0] rd_q[$];
	logic [4:0]  src_q[$];
	logic [1:0]  wr_q[$];
	logic [9:0]  ra[6];
	logic [7:0]  mk[6];

	core_model core_u (.sys_clk, .go, .f, .len, .kind, .irq_flag, .instr_last_cycle,
		.instr_writes_int_cfg, .instr_is_return_from_interrupt, .instr_is_ret, .busy);
	interrupt_priority_vectoring #(.NUM_SRC(18)) dut_u (.sys_clk, .srst, .irq_flag,
		.instr_last_cycle, .instr_writes_int_cfg, .instr_is_return_from_interrupt, .instr_is_ret, .call_start,
		.call_busy, .call_push_pc, .call_save_status, .call_load_vector, .call_source, .pop_pc,
		.flag_ack_valid, .flag_ack_source, .in_service, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task end_sim;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// Oldest note compared when a result appears
	always @(negedge sys_clk) begin
		if (call_start === 1'b1) n_call++;
		if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
			checked++;
			if (rd_q.size() == 0 || {s_axi_rresp, s_axi_rdata} !== rd_q.pop_front()) begin
				$display("MISMATCH %0t read %h", $time, s_axi_rdata);
				error_cnt++;
			end
		end
		if (flag_ack_valid === 1'b1) begin
			checked++;
			if (src_q.size() == 0 || flag_ack_source !== src_q.pop_front()) begin
				$display("MISMATCH %0t vector source %0d", $time, flag_ack_source);
				error_cnt++;
			end
		end
		// Write response against the oldest noted response
		if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
			checked++;
			if (wr_q.size() == 0 || s_axi_bresp !== wr_q.pop_front()) begin
				$display("MISMATCH %0t write response %h", $time, s_axi_bresp);
				error_cnt++;
			end
		end
	end

	task wr(input logic [9:0] a, input logic [31:0] v, input logic [1:0] e);
		logic aw, w, b;
		wr_q.push_back(e);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge sys_clk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid;
			@(posedge sys_clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
		end while (b !== 1'b1);
	endtask

	task rd(input logic [9:0] a, input logic [33:0] e);
		logic ar, r;
		rd_q.push_back(e);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge sys_clk);
			ar = s_axi_arvalid & s_axi_arready;
			r = s_axi_rvalid;
			@(posedge sys_clk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (r) s_axi_rready <= 1'b0;
		end while (r !== 1'b1);
	endtask

	task instr(input logic [17:0] fv, input logic [1:0] ln, input logic [2:0] kd,
		input int calls, input logic [4:0] src);
		int c0;
		c0 = n_call;
		if (calls > 0) src_q.push_back(src);
		@(posedge sys_clk);
		f <= fv;
		len <= ln;
		kind <= kd;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		do @(negedge sys_clk); while (busy);
		repeat (5) @(posedge sys_clk);
		checked++;
		if (n_call - c0 != calls) begin
			$display("MISMATCH %0t call count %0d", $time, n_call - c0);
			error_cnt++;
		end
	endtask

	// Watchdog
	initial begin
		repeat (5000) @(posedge sys_clk);
		error_cnt++;
		end_sim;
	end

	// Main sequence
	initial begin
		{go, f, len, kind, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		srst = 1'b1;
		{error_cnt, checked, n_call} = '0;
		d = 32'h2307;
		ra = '{{`IDX_PRIO_HIGH_BASE, 2'b00}, {`IDX_PRIO_LOW_BASE, 2'b00},
			{`IDX_PRIO_LOW_EXT, 2'b00}, {`IDX_PRIO_HIGH_EXT, 2'b00},
			{`IDX_PRIO_LOW_EXT_SECOND, 2'b00}, {`IDX_PRIO_HIGH_EXT_SECOND, 2'b00}};
		mk = '{8'h7f, 8'h7f, 8'hff, 8'hff, 8'h07, 8'h07};
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(ra[i], 34'h0);
			d = lfsr(d);
			wr(ra[i], d, 2'b00);
			rd(ra[i], {26'h0, d[7:0] & mk[i]});
			wr(ra[i], 32'h0, 2'b00);
		end
		rd(10'h004, {2'b10, 32'h0});
		wr(10'h008, 32'h5a, 2'b10);
		// Lane 0 strobe low: write must be ignored
		s_axi_wstrb <= 4'he;
		wr(ra[2], 32'hff, 2'b00);
		rd(ra[2], 34'h0);
		s_axi_wstrb <= 4'hf;
		wr(ra[1], 32'h22, 2'b00);
		wr(ra[0], 32'h20, 2'b00);
		instr(18'h9, 2'h2, 3'h0, 1, 5'd3);
		rd(10'h100, 34'h2);
		instr(18'h9, 2'h1, 3'h0, 0, 5'd0);
		instr(18'h2, 2'h3, 3'h0, 1, 5'd1);
		rd(10'h100, 34'ha);
		instr(18'h1, 2'h1, 3'h0, 0, 5'd0);
		instr(18'h0, 2'h1, 3'h4, 0, 5'd0);
		rd(10'h100, 34'ha);
		instr(18'h0, 2'h1, 3'h2, 0, 5'd0);
		rd(10'h100, 34'h2);
		instr(18'h0, 2'h1, 3'h2, 0, 5'd0);
		rd(10'h100, 34'h0);
		instr(18'h60, 2'h1, 3'h1, 0, 5'd0);
		instr(18'h60, 2'h2, 3'h2, 0, 5'd0);
		instr(18'h0, 2'h1, 3'h0, 0, 5'd0);
		instr(18'h60, 2'h2, 3'h0, 1, 5'd5);
		rd(10'h104, 34'h5);
		end_sim;
	end
endmodule

bind interrupt_priority_vectoring intc_checker #(.NUM_SRC(NUM_SRC)) chk_u (.sys_clk, .srst,
	.irq_flag, .instr_last_cycle, .instr_writes_int_cfg, .instr_is_return_from_interrupt, .instr_is_ret,
	.call_start, .call_busy, .call_push_pc, .call_save_status, .call_load_vector, .call_source,
	.pop_pc, .flag_ack_valid, .flag_ack_source, .in_service);
